// *** dbgcs_pins.sv ***
module dbgcs_pins
	import dbgcs_pkg::*;
(
	input wire logic MCLK,
	input wire logic bank_req,
	input wire logic hot_req,
	output logic BANK_CHOICE,
	output logic THERMAL_SHUTDOWN
);
	timeunit 1ns;
	timeprecision 100ps;
	initial BANK_CHOICE = 1'h0;
	initial THERMAL_SHUTDOWN = 1'h0;
	always @(posedge MCLK) BANK_CHOICE <= bank_req;
	always @(posedge MCLK) THERMAL_SHUTDOWN <= hot_req;
endmodule

// *** dbgcs_pkg.sv ***
package dbgcs_pkg;

	localparam int NUM_CH = 14;
	localparam int GRP_CH = 7;
	localparam int CODE_W = 8;
	localparam int ADDR_W = 12;

	typedef logic [CODE_W-1:0] dbgcs_code_t;
	typedef logic [1:0] dbgcs_cnt_t;

	typedef enum logic {
		DBGCS_BANK_A,
		DBGCS_BANK_B
	} dbgcs_bank_e;

	// Codes presented to the channel converters, grouped per reference pair
	typedef struct packed {
		dbgcs_code_t [GRP_CH-1:0] upper;
		dbgcs_code_t [GRP_CH-1:0] lower;
	} dbgcs_codes_s;

	// Live state shown in the status register
	typedef struct packed {
		dbgcs_cnt_t cnt_b;
		dbgcs_cnt_t cnt_a;
		logic bank_sel;
		logic thermal;
		logic out_en;
	} dbgcs_status_s;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
	localparam logic [ADDR_W-1:0] STAT_OFS = 12'h004;
	localparam logic [ADDR_W-1:0] CODE_BASE_OFS = 12'h040;
	localparam logic [5:0] CODE_PAGE = 6'h01;

	// Control field positions and reset values
	localparam int WR_DESIG_POS = 1;
	localparam int RD_DESIG_POS = 2;
	localparam logic CTRL_RST = 1'h0;
	localparam dbgcs_code_t CODE_RST = 8'h00;
	localparam dbgcs_cnt_t CNT_RST = 2'h0;
	localparam dbgcs_cnt_t FILL_TARGET = 2'h2;
	localparam logic [31:0] RDATA_RST = 32'h00000000;

	// Bank switch bound against the clock rate
	localparam int CLK_MHZ = 40;
	localparam int SWITCH_NS = 500;
	localparam int SWITCH_CYC = (SWITCH_NS * CLK_MHZ) / 1000;

endpackage

// *** dbgcs_props.sv ***
module dbgcs_props
	import dbgcs_pkg::*;
(
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic BANK_CHOICE,
	input wire logic THERMAL_SHUTDOWN,
	input wire dbgcs_codes_s CHANNEL_CODES,
	input wire logic [NUM_CH-1:0] CHANNEL_OUT_EN,
	input wire logic STATIC_REF_EN,
	input wire logic ACTIVE_BANK
);
	logic [2:0] wr_n_q;
	logic full_q;
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (!RESET_N);
	// Counts code writes, notes first enable
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wr_n_q <= 3'h0;
			full_q <= 1'h0;
		end else begin
			if (PSEL && PENABLE && PWRITE && PADDR[6] && wr_n_q != 3'h4) begin
				wr_n_q <= wr_n_q + 3'h1;
			end
			if (CHANNEL_OUT_EN[0]) begin
				full_q <= 1'h1;
			end
		end
	end
	static_ref_a: assert property (STATIC_REF_EN) else $error("ref off");
	en_same_a: assert property (&CHANNEL_OUT_EN || !(|CHANNEL_OUT_EN)) else $error("split");
	hot_off_a: assert property (THERMAL_SHUTDOWN [*6] |-> !(|CHANNEL_OUT_EN))
		else $error("hot enabled");
	hot_exit_a: assert property (full_q ##0 !THERMAL_SHUTDOWN [*8] |-> CHANNEL_OUT_EN[0])
		else $error("not restored");
	fill_gate_a: assert property (|CHANNEL_OUT_EN |-> wr_n_q == 3'h4) else $error("early");
	reset_clear_a: assert property ($rose(RESET_N) |-> CHANNEL_CODES == '0) else $error("dirty");
	bank_follow_a: assert property ($changed(BANK_CHOICE) ##1 $stable(BANK_CHOICE) [*8]
		|-> ACTIVE_BANK == BANK_CHOICE) else $error("slow switch");
	codes_hold_a: assert property (!PSEL [*3] ##0 $stable(ACTIVE_BANK) [*3]
		|-> $stable(CHANNEL_CODES)) else $error("codes moved");
	cover property (|CHANNEL_OUT_EN);
	cover property ($rose(ACTIVE_BANK));
	cover property (full_q && !CHANNEL_OUT_EN[0]);
endmodule

bind dbgcs_top dbgcs_props u_props (.MCLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
	.BANK_CHOICE, .THERMAL_SHUTDOWN, .CHANNEL_CODES, .CHANNEL_OUT_EN, .STATIC_REF_EN,
	.ACTIVE_BANK);

// *** dbgcs_sync3.sv ***
module dbgcs_sync3
	import dbgcs_pkg::*;
#(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic RAW,
	output logic LEVEL
);

	logic ff1_q;
	logic ff2_q;
	logic ff3_q;
	logic level_q;
	logic agree;

	// Change counts only once stages two and three agree
	assign agree = (ff2_q == ff3_q);

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ff1_q <= RST_VAL;
			ff2_q <= RST_VAL;
			ff3_q <= RST_VAL;
		end else begin
			ff1_q <= RAW;
			ff2_q <= ff1_q;
			ff3_q <= ff2_q;
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			level_q <= RST_VAL;
		end else if (agree) begin
			level_q <= ff3_q;
		end
	end

	assign LEVEL = level_q;

endmodule

// *** dbgcs_tb.sv ***
module testbench
	import dbgcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
		$display("mismatch %0t %h %h", $time, a, b); end end
	logic MCLK = 1'h0;
	logic RESET_N = 1'h0;
	logic PSEL = 1'h0;
	logic PENABLE = 1'h0;
	logic PWRITE = 1'h0;
	logic [ADDR_W-1:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA, rd;
	logic PREADY, PSLVERR, BANK_CHOICE, THERMAL_SHUTDOWN, STATIC_REF_EN, ACTIVE_BANK, err;
	logic bank_req = 1'h0;
	logic hot_req = 1'h0;
	dbgcs_codes_s CHANNEL_CODES, exp_c;
	logic [NUM_CH-1:0] CHANNEL_OUT_EN;
	int bad_count = 0;
	int n_checks = 0;
	dbgcs_pins pins (.MCLK, .bank_req, .hot_req, .BANK_CHOICE, .THERMAL_SHUTDOWN);
	dbgcs_top dut (.MCLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
		.PREADY, .PSLVERR, .BANK_CHOICE, .THERMAL_SHUTDOWN, .CHANNEL_CODES,
		.CHANNEL_OUT_EN, .STATIC_REF_EN, .ACTIVE_BANK);
	initial forever #12.5 MCLK = ~MCLK;
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'h1;
		do begin
			@(posedge MCLK);
			n++;
		end while (PREADY !== 1'h1 && n < 64);
		if (n == 64) bad_count++;
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		@(posedge MCLK);
	endtask
	task automatic bank(input dbgcs_code_t b);
		for (int k = 0; k < NUM_CH; k++) begin
			apb(1'h1, CODE_BASE_OFS + 12'(4 * k), {24'h0, b + 8'(k)});
		end
	endtask
	task automatic fill(input dbgcs_code_t b);
		for (int i = 0; i < GRP_CH; i++) begin
			exp_c.upper[i] = b + 8'(i);
			exp_c.lower[i] = b + 8'(i + 7);
		end
	endtask
	initial begin
		repeat (5000) @(posedge MCLK);
		bad_count++;
		report_and_stop();
	end
	initial begin
		repeat (16) @(posedge MCLK);
		RESET_N <= 1'h1;
		repeat (2) @(posedge MCLK);
		`CHK(CHANNEL_CODES, 112'h0)
		`CHK(PREADY, 1'h1)
		apb(1'h0, CTRL_OFS, 32'h0);
		`CHK(rd, 32'h0)
		$display("reset done");
		bank(8'h10);
		apb(1'h1, CTRL_OFS, 32'h2);
		apb(1'h1, CODE_BASE_OFS, 32'h80);
		`CHK(CHANNEL_OUT_EN, 14'h0)
		apb(1'h1, CODE_BASE_OFS + 12'h004, 32'h81);
		repeat (2) @(posedge MCLK);
		`CHK(CHANNEL_OUT_EN, 14'h3FFF)
		$display("fill done");
		apb(1'h0, STAT_OFS, 32'h0);
		`CHK(rd, 32'h51)
		`CHK(err, 1'h0)
		apb(1'h1, STAT_OFS, 32'hFF);
		`CHK(err, 1'h1)
		apb(1'h1, CODE_BASE_OFS + 12'h001, 32'hFF);
		`CHK(err, 1'h1)
		bank(8'h80);
		fill(8'h10);
		`CHK(CHANNEL_CODES, exp_c)
		apb(1'h1, CTRL_OFS, 32'h4);
		apb(1'h0, CODE_BASE_OFS + 12'h034, 32'h0);
		`CHK(rd, 32'h8D)
		apb(1'h1, CTRL_OFS, 32'h0);
		apb(1'h0, CODE_BASE_OFS + 12'h034, 32'h0);
		`CHK(rd, 32'h1D)
		$display("banks done");
		bank_req <= 1'h1;
		repeat (21) @(posedge MCLK);
		fill(8'h80);
		`CHK(CHANNEL_CODES, exp_c)
		`CHK(ACTIVE_BANK, 1'h1)
		hot_req <= 1'h1;
		repeat (8) @(posedge MCLK);
		`CHK(CHANNEL_OUT_EN, 14'h0)
		`CHK(STATIC_REF_EN, 1'h1)
		`CHK(CHANNEL_CODES, exp_c)
		hot_req <= 1'h0;
		repeat (8) @(posedge MCLK);
		`CHK(CHANNEL_OUT_EN, 14'h3FFF)
		$display("thermal done");
		apb(1'h0, 12'h100, 32'h0);
		`CHK(err, 1'h1)
		`CHK(rd, 32'h0)
		RESET_N <= 1'h0;
		repeat (2) @(posedge MCLK);
		RESET_N <= 1'h1;
		repeat (2) @(posedge MCLK);
		`CHK(CHANNEL_CODES, 112'h0)
		`CHK(CHANNEL_OUT_EN, 14'h0)
		$display("rerun done");
		report_and_stop();
	end
endmodule

// *** dbgcs_top.sv ***
// Function
// (R1) Outputs show bank A codes when bank choice low, bank B when high.
// (R2) Writes to the idle bank never disturb the codes being presented.
// (R3) A bank change reaches the outputs well inside 500 ns.
// (R4) Reset clears every code register of both banks to zero.
// (R5) Channel outputs stay off until each bank got two data bytes.
// (R6) Thermal shutdown turns all fourteen channel outputs off.
// (R7) The four fixed reference buffers stay enabled during thermal shutdown.
// (R8) Leaving thermal shutdown restores outputs from the stored codes.
// (R9) Fourteen 8-bit channels per bank, seven upper then seven lower.
// (R10) Each code is an unsigned byte, bit seven most significant.
// (R11) Codes span linearly from low reference (0) to high reference (255).
// (R12) Upper codes go to the upper pair, lower codes to the lower pair.
// (R13) Write designator picks the written bank, zero is A; reset clears it.
// (R14) Read designator picks the read bank, zero is A; reset clears it.
// (R15) Each bank holds fourteen separately addressable code registers.
// (R16) Per-bank written-byte counts saturate at two; enable needs both at two.
// (R17) Thermal input is synchronised and gates enable without touching codes.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
module dbgcs_top
	import dbgcs_pkg::*;
(
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic BANK_CHOICE,
	input wire logic THERMAL_SHUTDOWN,
	output dbgcs_codes_s CHANNEL_CODES,
	output logic [NUM_CH-1:0] CHANNEL_OUT_EN,
	output logic STATIC_REF_EN,
	output logic ACTIVE_BANK
);

	// Storage for both banks
	dbgcs_code_t bank_a_q [NUM_CH];
	dbgcs_code_t bank_b_q [NUM_CH];

	logic wr_desig_q;
	logic rd_desig_q;
	dbgcs_cnt_t cnt_a_q;
	dbgcs_cnt_t cnt_b_q;

	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic pslverr_q;
	logic pslverr_d;
	logic pready_q;

	dbgcs_codes_s codes_q;
	dbgcs_codes_s codes_d;
	logic [NUM_CH-1:0] out_en_q;
	logic [NUM_CH-1:0] out_en_d;
	logic static_en_q;
	logic active_bank_q;

	logic bank_sel_s;
	logic thermal_s;

	// Pins from outside the clock domain
	dbgcs_sync3 #(
		.RST_VAL(1'b0)
	) u_bank_sync (
		.MCLK(MCLK),
		.RESET_N(RESET_N),
		.RAW(BANK_CHOICE),
		.LEVEL(bank_sel_s)
	);

	// (R17) Synchronised thermal flag
	dbgcs_sync3 #(
		.RST_VAL(1'b0)
	) u_therm_sync (
		.MCLK(MCLK),
		.RESET_N(RESET_N),
		.RAW(THERMAL_SHUTDOWN),
		.LEVEL(thermal_s)
	);

	// Bus phase decode
	logic setup_ph;
	logic access_ph;
	logic wr_xfer;
	assign setup_ph = PSEL & ~PENABLE;
	assign access_ph = PSEL & PENABLE & pready_q;
	assign wr_xfer = access_ph & PWRITE;

	// Address decode
	logic aligned;
	logic hit_ctrl;
	logic hit_stat;
	logic hit_code;
	logic [3:0] code_idx;
	assign aligned = (PADDR[1:0] == 2'h0);
	assign code_idx = PADDR[5:2];
	assign hit_ctrl = aligned && (PADDR == CTRL_OFS);
	assign hit_stat = aligned && (PADDR == STAT_OFS);
	// (R15) Fourteen code slots per bank
	assign hit_code = aligned && (PADDR[ADDR_W-1:6] == CODE_PAGE)
		&& (code_idx < 4'(NUM_CH));

	// Write strobes
	logic wr_ctrl;
	logic wr_code;
	logic wr_code_a;
	logic wr_code_b;
	assign wr_ctrl = wr_xfer & hit_ctrl;
	assign wr_code = wr_xfer & hit_code;
	// (R13) Designator steers the written bank
	assign wr_code_a = wr_code & (wr_desig_q == DBGCS_BANK_B ? 1'b0 : 1'b1);
	assign wr_code_b = wr_code & (wr_desig_q == DBGCS_BANK_B);

	// (R10) Low byte, bit seven first on the wire and most significant here
	dbgcs_code_t wr_byte;
	assign wr_byte = PWDATA[CODE_W-1:0];

	// (R4) Code registers cleared by reset
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
			logic sel_slot;
			assign sel_slot = (code_idx == 4'(gi));
			// (R2) Only the addressed slot of the chosen bank changes
			always_ff @(posedge MCLK or negedge RESET_N) begin
				if (!RESET_N) begin
					bank_a_q[gi] <= CODE_RST;
				end else if (wr_code_a && sel_slot) begin
					bank_a_q[gi] <= wr_byte;
				end
			end
			always_ff @(posedge MCLK or negedge RESET_N) begin
				if (!RESET_N) begin
					bank_b_q[gi] <= CODE_RST;
				end else if (wr_code_b && sel_slot) begin
					bank_b_q[gi] <= wr_byte;
				end
			end
		end
	endgenerate

	// (R13) Write designator
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wr_desig_q <= CTRL_RST;
		end else if (wr_ctrl) begin
			wr_desig_q <= PWDATA[WR_DESIG_POS];
		end
	end

	// (R14) Read designator
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rd_desig_q <= CTRL_RST;
		end else if (wr_ctrl) begin
			rd_desig_q <= PWDATA[RD_DESIG_POS];
		end
	end

	// (R16) Saturating per-bank byte counts
	logic full_a;
	logic full_b;
	assign full_a = (cnt_a_q == FILL_TARGET);
	assign full_b = (cnt_b_q == FILL_TARGET);

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cnt_a_q <= CNT_RST;
		end else if (wr_code_a && !full_a) begin
			cnt_a_q <= cnt_a_q + 2'h1;
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cnt_b_q <= CNT_RST;
		end else if (wr_code_b && !full_b) begin
			cnt_b_q <= cnt_b_q + 2'h1;
		end
	end

	// Read path
	dbgcs_code_t rd_code;
	dbgcs_status_s stat;
	logic [31:0] ctrl_word;
	logic [31:0] stat_word;
	logic [31:0] code_word;
	// (R14) Read bank picked by designator
	assign rd_code = (rd_desig_q == DBGCS_BANK_B) ? bank_b_q[code_idx] : bank_a_q[code_idx];
	assign ctrl_word = {29'h0, rd_desig_q, wr_desig_q, 1'b0};
	assign stat.cnt_b = cnt_b_q;
	assign stat.cnt_a = cnt_a_q;
	assign stat.bank_sel = active_bank_q;
	assign stat.thermal = thermal_s;
	assign stat.out_en = out_en_q[0];
	assign stat_word = {25'h0, stat};
	assign code_word = {24'h0, rd_code};

	// Read data and error prepared during setup
	logic wr_to_ro;
	logic unmapped;
	assign wr_to_ro = PWRITE & hit_stat;
	assign unmapped = ~(hit_ctrl | hit_stat | hit_code);
	assign pslverr_d = setup_ph & (unmapped | wr_to_ro);
	assign prdata_d = (!setup_ph || PWRITE) ? RDATA_RST :
		hit_ctrl ? ctrl_word :
		hit_stat ? stat_word :
		hit_code ? code_word : RDATA_RST;

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			prdata_q <= RDATA_RST;
			pslverr_q <= 1'b0;
			pready_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
			pready_q <= 1'b1;
		end
	end

	// (R1) Bank choice picks the presented codes
	// (R9) Channels 1 to 7 upper, 8 to 14 lower
	// (R12) Each group feeds its own reference pair
	generate
		for (gi = 0; gi < GRP_CH; gi++) begin : g_grp
			assign codes_d.upper[gi] = bank_sel_s ? bank_b_q[gi] : bank_a_q[gi];
			assign codes_d.lower[gi] = bank_sel_s ? bank_b_q[gi+GRP_CH] : bank_a_q[gi+GRP_CH];
		end
	endgenerate

	// (R5) Enable only after both banks are filled
	// (R6) Thermal shutdown overrides the enable
	assign out_en_d = {NUM_CH{full_a & full_b & ~thermal_s}};

	// (R3) Synchroniser plus one stage, far under SWITCH_CYC
	// (R8) Codes kept through shutdown, enable returns alone
	// (R11) Raw linear codes drive the converters
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			codes_q <= '0;
			out_en_q <= '0;
			active_bank_q <= 1'b0;
		end else begin
			codes_q <= codes_d;
			out_en_q <= out_en_d;
			active_bank_q <= bank_sel_s;
		end
	end

	// (R7) Fixed buffers on regardless of thermal state
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			static_en_q <= 1'b1;
		end else begin
			static_en_q <= 1'b1;
		end
	end

	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign CHANNEL_CODES = codes_q;
	assign CHANNEL_OUT_EN = out_en_q;
	assign STATIC_REF_EN = static_en_q;
	assign ACTIVE_BANK = active_bank_q;

endmodule
